//--- frame_rate_exposure_timing.v
// frame_rate_exposure_timing.v: line, pixel and array clock enables,
// row and frame counters, rolling reset lead, gain and break-point regs
// assumes an apb master on pclk; capture receiver samples pixel_tick
`default_nettype none
`include "frame_timing_regs.vh"

// Summary of operation
// - line clock is input divided by 1..31
// - line divisor changes at frame after apply
// - array divisor applied same way, not exposure
// - pixel clock equals line, halved when horizontally sub-sampled
// - row lasts 780 line cycles plus extension
// - row extension 0 to 2047 line cycles
// - row, frame, lead settings pending until apply
// - scan rows equal end minus start plus one
// - frame rows scale by mode factor plus extension
// - frame extension 0 to 4096 rows
// - reset row lies reset lead rows ahead
// - six-bit video gain code stored
// - red, green, blue six-bit gain codes stored
// - two break points, level and sensitivity each
// - levels set knees, sensitivities set later slopes
// - scan rows from doubled registers and low bit
module frame_rate_exposure_timing #(
    parameter ROW_EXT_W = 11,
    parameter FRAME_EXT_W = 13
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg line_tick,
    output reg pixel_tick,
    output reg array_tick,
    output reg frame_start,
    output reg [8:0] read_row,
    output reg [8:0] reset_row,
    output reg reset_row_valid,
    output reg route_green,
    output reg [5:0] video_gain_code,
    output reg [5:0] red_gain,
    output reg [5:0] green_gain,
    output reg [5:0] blue_gain
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    reg [4:0] pend_line_div;
    reg [4:0] pend_array_div;
    reg [ROW_EXT_W-1:0] pend_row_ext;
    reg [FRAME_EXT_W-1:0] pend_frame_ext;
    reg [11:0] pend_lead;
    reg [7:0] pend_scan_start;
    reg [7:0] pend_scan_end;
    reg [1:0] pend_mode;
    reg pend_hsub;
    reg pend_low_bit;
    reg apply_flag;
    reg [31:0] break_pts;
    reg [15:0] frame_count;
    reg [31:0] next_prdata;

    // ----------------------------------------------------------------
    // active copies
    // ----------------------------------------------------------------
    reg [4:0] line_clock_divisor;
    reg [4:0] array_clock_divisor;
    reg [ROW_EXT_W-1:0] row_extension;
    reg [FRAME_EXT_W-1:0] frame_extension;
    reg [11:0] reset_lead;
    reg [8:0] scan_start;
    reg [8:0] scan_row_count;
    reg [1:0] row_mode_scale;
    reg hsub;

    // counters
    reg [4:0] line_cnt;
    reg [4:0] array_cnt;
    reg pixel_phase;
    reg [11:0] row_cyc;
    reg [13:0] row_idx;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire wr = psel && penable && pwrite;
    wire rd_setup = psel && !penable;
    wire hit_apply = wr && (paddr == `OFF_APPLY) && pwdata[0];
    wire frame_bound;
    wire row_end;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a <= `OFF_FRAME_CNT) && (a[1:0] == 2'b00);
        end
    endfunction

    // divisor zero is held at one so the range stays 1..31
    function [4:0] clamp_div;
        input [4:0] d;
        begin
            clamp_div = (d == 5'h00) ? 5'h01 : d;
        end
    endfunction

    // ----------------------------------------------------------------
    // read data mux
    // ----------------------------------------------------------------
    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFF_CLK_DIV: next_prdata = {19'h0, pend_array_div,
                3'h0, pend_line_div};
            `OFF_APPLY: next_prdata = {31'h0, apply_flag};
            `OFF_ROW_EXT: next_prdata = {21'h0, pend_row_ext};
            `OFF_FRAME_EXT: next_prdata = {19'h0, pend_frame_ext};
            `OFF_RESET_LEAD: next_prdata = {20'h0, pend_lead};
            `OFF_SCAN_WIN: next_prdata = {16'h0, pend_scan_end,
                pend_scan_start};
            `OFF_MODE: next_prdata = {27'h0, pend_low_bit,
                route_green, pend_hsub, pend_mode};
            `OFF_GAIN: next_prdata = {8'h0, blue_gain, green_gain,
                red_gain, video_gain_code};
            `OFF_BREAK_PT: next_prdata = break_pts;
            `OFF_STATUS: next_prdata = {9'h0, scan_row_count, row_idx};
            `OFF_FRAME_CNT: next_prdata = {16'h0, frame_count};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // apb slave: one wait-free access, error on unmapped word
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup && !is_mapped(paddr);
            if (rd_setup && !pwrite)
                prdata <= next_prdata;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_line_div <= `RST_LINE_DIV;
            pend_array_div <= `RST_ARRAY_DIV;
            pend_row_ext <= {ROW_EXT_W{1'b0}};
            pend_frame_ext <= {FRAME_EXT_W{1'b0}};
            pend_lead <= 12'h000;
            pend_scan_start <= 8'h00;
            pend_scan_end <= `RST_SCAN_END;
            pend_mode <= `MODE_PROG;
            pend_hsub <= 1'b0;
            pend_low_bit <= 1'b0;
            route_green <= 1'b0;
            video_gain_code <= 6'h00;
            red_gain <= 6'h00;
            green_gain <= 6'h00;
            blue_gain <= 6'h00;
            break_pts <= 32'h0000_0000;
            apply_flag <= 1'b0;
        end else begin
            if (wr) begin
                case (paddr)
                    `OFF_CLK_DIV: begin
                        pend_line_div <= pwdata[`LINE_DIV_LSB +: 5];
                        pend_array_div <= pwdata[`ARRAY_DIV_LSB +: 5];
                    end
                    `OFF_ROW_EXT: pend_row_ext <= pwdata[ROW_EXT_W-1:0];
                    `OFF_FRAME_EXT: begin
                        // extension tops out at 4096 rows
                        if (pwdata[12:0] > 13'h1000)
                            pend_frame_ext <= 13'h1000;
                        else
                            pend_frame_ext <= pwdata[FRAME_EXT_W-1:0];
                    end
                    `OFF_RESET_LEAD: pend_lead <= pwdata[11:0];
                    `OFF_SCAN_WIN: begin
                        pend_scan_start <= pwdata[7:0];
                        pend_scan_end <= pwdata[15:8];
                    end
                    `OFF_MODE: begin
                        pend_mode <= pwdata[1:0];
                        pend_hsub <= pwdata[`MODE_HSUB_BIT];
                        route_green <= pwdata[`MODE_ROUTE_BIT];
                        pend_low_bit <= pwdata[`MODE_LOWBIT_BIT];
                    end
                    `OFF_GAIN: begin
                        video_gain_code <= pwdata[5:0];
                        red_gain <= pwdata[11:6];
                        green_gain <= pwdata[17:12];
                        blue_gain <= pwdata[23:18];
                    end
                    // two knees: level/sensitivity byte pairs
                    `OFF_BREAK_PT: break_pts <= pwdata;
                    default: ;
                endcase
            end
            // set by write wins over frame clear
            if (hit_apply)
                apply_flag <= 1'b1;
            else if (frame_bound)
                apply_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // clock enables
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cnt <= 5'h00;
            array_cnt <= 5'h00;
            pixel_phase <= 1'b0;
            line_tick <= 1'b0;
            array_tick <= 1'b0;
            pixel_tick <= 1'b0;
        end else begin
            if (line_cnt + 5'h01 >= line_clock_divisor) begin
                line_cnt <= 5'h00;
                line_tick <= 1'b1;
                pixel_phase <= ~pixel_phase;
                pixel_tick <= !hsub || pixel_phase;
            end else begin
                line_cnt <= line_cnt + 5'h01;
                line_tick <= 1'b0;
                pixel_tick <= 1'b0;
            end
            if (array_cnt + 5'h01 >= array_clock_divisor) begin
                array_cnt <= 5'h00;
                array_tick <= 1'b1;
            end else begin
                array_cnt <= array_cnt + 5'h01;
                array_tick <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // row and frame counters
    // ----------------------------------------------------------------
    wire [13:0] scan_scaled = (row_mode_scale == `MODE_PROG) ?
        {5'h00, scan_row_count} : {6'h00, scan_row_count[8:1]};
    wire [13:0] frame_rows = scan_scaled + {1'b0, frame_extension};
    wire [11:0] row_len = `ROW_FIXED_CYCLES + {1'b0, row_extension};
    assign row_end = line_tick && (row_cyc + 12'h001 >= row_len);
    assign frame_bound = row_end && (row_idx + 14'h0001 >= frame_rows);

    // ----------------------------------------------------------------
    // scan window and reset lead
    // ----------------------------------------------------------------
    wire [8:0] next_start = {pend_scan_start, pend_low_bit};
    wire [8:0] next_end = {pend_scan_end, 1'b1} + {8'h00, pend_low_bit};
    wire [13:0] lead_row = row_idx + {2'h0, reset_lead};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_cyc <= 12'h000;
            row_idx <= 14'h0000;
            frame_start <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            frame_start <= frame_bound;
            if (row_end)
                row_cyc <= 12'h000;
            else if (line_tick)
                row_cyc <= row_cyc + 12'h001;
            if (frame_bound) begin
                row_idx <= 14'h0000;
                frame_count <= frame_count + 16'h0001;
            end else if (row_end) begin
                row_idx <= row_idx + 14'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // settings transfer at frame boundary
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_clock_divisor <= `RST_LINE_DIV;
            array_clock_divisor <= `RST_ARRAY_DIV;
            row_extension <= {ROW_EXT_W{1'b0}};
            frame_extension <= {FRAME_EXT_W{1'b0}};
            reset_lead <= 12'h000;
            scan_start <= 9'h000;
            scan_row_count <= 9'h1F8;
            row_mode_scale <= `MODE_PROG;
            hsub <= 1'b0;
        end else if (frame_bound && apply_flag) begin
            // every pending setting moves in one edge
            line_clock_divisor <= clamp_div(pend_line_div);
            array_clock_divisor <= clamp_div(pend_array_div);
            row_extension <= pend_row_ext;
            frame_extension <= pend_frame_ext;
            reset_lead <= pend_lead;
            scan_start <= next_start;
            scan_row_count <= next_end - next_start + 9'h001;
            row_mode_scale <= pend_mode;
            hsub <= pend_hsub;
        end
    end

    // ----------------------------------------------------------------
    // read and reset row outputs
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_row <= 9'h000;
            reset_row <= 9'h000;
            reset_row_valid <= 1'b0;
        end else begin
            read_row <= scan_start + row_idx[8:0];
            reset_row <= scan_start + lead_row[8:0];
            // valid only while the lead row is inside the scan
            reset_row_valid <= (reset_lead != 12'h000) &&
                (lead_row < {5'h00, scan_row_count});
        end
    end
endmodule // frame_rate_exposure_timing
`default_nettype wire

//--- frame_timing_regs.vh
// frame_timing_regs.vh: apb offsets, field positions, resets, timing counts
// assumes a 32-bit apb slave with one register per aligned word
`ifndef FRAME_TIMING_REGS_VH
`define FRAME_TIMING_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CLK_DIV 12'h000
`define OFF_APPLY 12'h004
`define OFF_ROW_EXT 12'h008
`define OFF_FRAME_EXT 12'h00C
`define OFF_RESET_LEAD 12'h010
`define OFF_SCAN_WIN 12'h014
`define OFF_MODE 12'h018
`define OFF_GAIN 12'h01C
`define OFF_BREAK_PT 12'h020
`define OFF_STATUS 12'h024
`define OFF_FRAME_CNT 12'h028
// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define LINE_DIV_LSB 0
`define ARRAY_DIV_LSB 8
`define MODE_PROG 2'h0
`define MODE_VSUB 2'h1
`define MODE_INTL 2'h2
`define MODE_HSUB_BIT 2
`define MODE_ROUTE_BIT 3
`define MODE_LOWBIT_BIT 4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RST_LINE_DIV 5'h01
`define RST_ARRAY_DIV 5'h01
`define RST_SCAN_END 8'hFB
`define ROW_FIXED_CYCLES 12'h30C
`endif

//--- frame_rate_exposure_timing_assertions.sv
// frame_rate_exposure_timing_assertions.sv: port checker for the timing block
// assumes one pclk domain and asynchronous active-low presetn
`default_nettype none
module frame_rate_exposure_timing_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic line_tick,
    input wire logic pixel_tick,
    input wire logic frame_start,
    input wire logic [8:0] read_row,
    input wire logic [8:0] reset_row,
    input wire logic reset_row_valid,
    input wire logic [5:0] video_gain_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_pixel_on_line: assert property (pixel_tick |-> line_tick)
        else $error("pixel tick without line tick");
    a_frame_pulse: assert property (frame_start |=> !frame_start [*8])
        else $error("frame start too long");
    a_gain_after_write: assert property ($changed(video_gain_code) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("gain changed without write");
    a_reset_ahead: assert property (reset_row_valid |-> reset_row > read_row)
        else $error("reset row not ahead");
    c_frame: cover property (frame_start);
    c_refused: cover property (pslverr);
    c_lead: cover property (reset_row_valid);
endmodule // frame_rate_exposure_timing_chk
bind frame_rate_exposure_timing frame_rate_exposure_timing_chk chk_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .line_tick, .pixel_tick, .frame_start, .read_row, .reset_row,
    .reset_row_valid, .video_gain_code);
`default_nettype wire

//--- capture_receiver.sv
// capture_receiver.sv: video port receiver counting pixels per frame
// assumes pixel_tick and frame_start are single-cycle pulses on pclk
`default_nettype none
module capture_receiver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pixel_tick,
    input wire logic frame_start,
    output var int pix_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // pixels seen between frame starts, latched at each start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            pix_count <= 0;
        end else if (frame_start) begin
            pix_count <= cnt;
            cnt <= int'(pixel_tick);
        end else begin
            cnt <= cnt + int'(pixel_tick);
        end
    end
endmodule // capture_receiver
`default_nettype wire

//--- tb_frame_rate_exposure_timing.sv
// tb_frame_rate_exposure_timing.sv: self-checking bench with apb master
// assumes the design header offsets and a 200 MHz pclk
`default_nettype none
module tb_frame_rate_exposure_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, line_tick, pixel_tick, array_tick, frame_start;
    logic reset_row_valid, route_green, err_seen;
    logic [8:0] read_row, reset_row;
    logic [5:0] video_gain_code, red_gain, green_gain, blue_gain;
    logic [23:0] g;
    logic [4:0] dv [2] = '{5'h01, 5'h03};
    logic [2:0] md [2] = '{3'h0, 3'h5};
    int err_count = 0;
    int cmp_count = 0;
    int pix, n, ext, lines, at;
    always #2.5 pclk = ~pclk;
    frame_rate_exposure_timing uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_tick,
        .pixel_tick, .array_tick, .frame_start, .read_row, .reset_row,
        .reset_row_valid, .route_green, .video_gain_code, .red_gain,
        .green_gain, .blue_gain);
    capture_receiver rx (.pclk, .presetn, .pixel_tick, .frame_start,
        .pix_count(pix));
    // ----------------------------------------------------------------
    // bus, compare and frame tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wait_frame(output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (frame_start !== 1'b1 && c < 500000);
        if (c >= 500000) err_count++;
    endtask
    task results;
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (600000) @(posedge pclk);
        err_count++;
        results;
    end
    initial begin
        void'($urandom(32'hAFC7));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000101);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0000FB00);
        apb(1'b0, 12'h030, 32'h0);
        chk({err_seen, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h008, 32'h0000FFFF);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h000007FF);
        g = 24'($urandom);
        apb(1'b1, 12'h01C, {8'h00, g});
        apb(1'b1, 12'h018, 32'h00000008);
        repeat (3) @(posedge pclk);
        chk({26'h0, video_gain_code}, {26'h0, g[5:0]});
        chk({blue_gain, green_gain, red_gain}, g[23:6]);
        chk({31'h0, route_green}, 32'h1);
        apb(1'b1, 12'h020, 32'h40004000);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h40004000);
        for (int i = 0; i < 2; i++) begin
            ext = $urandom_range(15, 0);
            apb(1'b1, 12'h000, {19'h0, 5'(i * 6 + 1), 3'h0, dv[i]});
            apb(1'b1, 12'h008, 32'(ext));
            apb(1'b1, 12'h00C, 32'(i));
            apb(1'b1, 12'h010, 32'h1);
            apb(1'b1, 12'h014, 32'h0);
            apb(1'b1, 12'h018, {29'h0, md[i]});
            apb(1'b1, 12'h004, 32'h1);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, 32'h1);
            wait_frame(n);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, 32'h0);
            wait_frame(n);
            wait_frame(n);
            lines = 2 * (780 + ext);
            chk(n, dv[i] * lines);
            @(posedge pclk);
            chk(pix, md[i][2] ? lines / 2 : lines);
            at = 0;
            repeat (42) begin
                @(posedge pclk);
                at += int'(array_tick);
            end
            chk(at, 42 / (i * 6 + 1));
        end
        results;
    end
endmodule // tb_frame_rate_exposure_timing
`default_nettype wire
